// [src/dac_test_pattern_sleep_regs.v]
// Test pattern, static output override and sleep routing registers with APB access.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs_map.vh"

module dac_test_pattern_sleep_regs #(
  parameter ADDR_W = 12,
  parameter DATA_W = 14
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire [DATA_W-1:0] data_in,
  input wire data_sync,
  input wire sleep_pin,
  output reg [DATA_W-1:0] dac_code,
  output reg sleep_dac_a,
  output reg sleep_dac_b,
  output reg sleep_fuse,
  output reg sleep_tsense,
  output reg sleep_clk_rx,
  output reg sleep_data_rx,
  output reg sleep_align_rx,
  output reg sleep_dataclk_rx
);

  localparam [127:0] PAT_RESETS = {
    `RST_WORD7, `RST_WORD6, `RST_WORD5, `RST_WORD4,
    `RST_WORD3, `RST_WORD2, `RST_WORD1, `RST_WORD0
  };

  // Bus decode.
  wire setup_ph;
  wire access_ph;
  wire wr_access;
  wire [7:0] reg_idx;
  wire aligned;
  wire upper_clear;
  reg idx_known;
  reg [15:0] rd_word;

  // Register contents.
  wire [127:0] pat_flat;
  wire [15:0] override_r;
  wire [15:0] sleep_mask_r;
  wire [15:0] check_ctrl_r;
  reg [7:0] word_err_r;

  // Synchronised pin inputs.
  reg [DATA_W-1:0] data_s1_r;
  reg [DATA_W-1:0] data_s2_r;
  reg sync_s1_r;
  reg sync_s2_r;
  reg sync_d_r;
  reg sleep_s1_r;
  reg sleep_s2_r;

  // Pattern checker.
  reg armed_r;
  reg [2:0] idx_r;
  wire sync_rise;
  wire chk_en;
  wire cmp_valid;
  wire [2:0] cmp_idx;
  wire [DATA_W-1:0] expected;
  wire mismatch;
  wire [7:0] err_set;
  wire [7:0] err_clr;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign reg_idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign upper_clear = (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});

  // The slave never inserts wait states.
  assign pready = 1'b1;

  always @* begin
    case (reg_idx)
      `IDX_WORD0, `IDX_WORD1, `IDX_WORD2, `IDX_WORD3,
      `IDX_WORD4, `IDX_WORD5, `IDX_WORD6, `IDX_WORD7,
      `IDX_OVERRIDE, `IDX_SLEEP_MASK,
      `IDX_CHECK_CTRL, `IDX_CHECK_STATUS: begin
        idx_known = aligned & upper_clear;
      end
      default: begin
        idx_known = 1'b0;
      end
    endcase
  end

  assign wr_access = access_ph & pwrite & idx_known;

  // Pattern words, each in its own register.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_word
      reg_word #(
        .RESET_VAL(PAT_RESETS[16*gi +: 16]),
        .WR_MASK(`WMASK_WORD)
      ) u_word (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_access & (reg_idx == (`IDX_WORD0 + gi[7:0]))),
        .wr_data(pwdata[15:0]),
        .value_r(pat_flat[16*gi +: 16])
      );
    end
  endgenerate

  reg_word #(
    .RESET_VAL(`RST_OVERRIDE),
    .WR_MASK(`WMASK_OVERRIDE)
  ) u_override (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & (reg_idx == `IDX_OVERRIDE)),
    .wr_data(pwdata[15:0]),
    .value_r(override_r)
  );

  reg_word #(
    .RESET_VAL(`RST_SLEEP_MASK),
    .WR_MASK(`WMASK_SLEEP)
  ) u_sleep_mask (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & (reg_idx == `IDX_SLEEP_MASK)),
    .wr_data(pwdata[15:0]),
    .value_r(sleep_mask_r)
  );

  reg_word #(
    .RESET_VAL(`RST_CHECK_CTRL),
    .WR_MASK(`WMASK_CHECK_CTRL)
  ) u_check_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & (reg_idx == `IDX_CHECK_CTRL)),
    .wr_data(pwdata[15:0]),
    .value_r(check_ctrl_r)
  );

  // Read data for the addressed register.
  always @* begin
    case (reg_idx)
      `IDX_WORD0: begin
        rd_word = pat_flat[15:0];
      end
      `IDX_WORD1: begin
        rd_word = pat_flat[31:16];
      end
      `IDX_WORD2: begin
        rd_word = pat_flat[47:32];
      end
      `IDX_WORD3: begin
        rd_word = pat_flat[63:48];
      end
      `IDX_WORD4: begin
        rd_word = pat_flat[79:64];
      end
      `IDX_WORD5: begin
        rd_word = pat_flat[95:80];
      end
      `IDX_WORD6: begin
        rd_word = pat_flat[111:96];
      end
      `IDX_WORD7: begin
        rd_word = pat_flat[127:112];
      end
      `IDX_OVERRIDE: begin
        rd_word = override_r;
      end
      `IDX_SLEEP_MASK: begin
        rd_word = sleep_mask_r;
      end
      `IDX_CHECK_CTRL: begin
        rd_word = check_ctrl_r;
      end
      `IDX_CHECK_STATUS: begin
        rd_word = {7'h00, armed_r, word_err_r};
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle and shown in the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= idx_known ? {16'h0000, rd_word} : 32'h00000000;
      pslverr <= ~idx_known;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // Two-flop synchronisers for the pins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_s1_r <= {DATA_W{1'b0}};
      data_s2_r <= {DATA_W{1'b0}};
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_d_r <= 1'b0;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      data_s1_r <= data_in;
      data_s2_r <= data_s1_r;
      sync_s1_r <= data_sync;
      sync_s2_r <= sync_s1_r;
      sync_d_r <= sync_s2_r;
      sleep_s1_r <= sleep_pin;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // Word zero is expected together with the sync rising edge.
  assign sync_rise = sync_s2_r & ~sync_d_r;
  assign chk_en = check_ctrl_r[`CHK_EN_BIT];
  assign cmp_valid = chk_en & (sync_rise | armed_r);
  assign cmp_idx = sync_rise ? 3'd0 : idx_r;
  assign expected = pat_flat[{cmp_idx, 4'h0} +: DATA_W];
  assign mismatch = (data_s2_r != expected);

  // The checker walks the eight words in order, restarting on each sync rising edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
      idx_r <= 3'd0;
    end else if (!chk_en) begin
      armed_r <= 1'b0;
      idx_r <= 3'd0;
    end else if (cmp_valid) begin
      armed_r <= 1'b1;
      idx_r <= cmp_idx + 3'd1;
    end
  end

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_err
      assign err_set[gi] = cmp_valid & mismatch & (cmp_idx == gi[2:0]);
    end
  endgenerate

  assign err_clr = (wr_access & (reg_idx == `IDX_CHECK_STATUS)) ? pwdata[7:0] : 8'h00;

  // Per-word mismatch flags are sticky; a new mismatch beats a clear in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_err_r <= 8'h00;
    end else begin
      word_err_r <= (word_err_r & ~err_clr) | err_set;
    end
  end

  // Converter code: static value while the override is enabled, stream otherwise.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code <= {DATA_W{1'b0}};
    end else if (override_r[`OVR_EN_BIT]) begin
      dac_code <= override_r[`OVR_CODE_MSB:0];
    end else begin
      dac_code <= data_s2_r;
    end
  end

  // Sleep requests follow the pin for every block whose mask bit is set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_dac_a <= 1'b0;
      sleep_dac_b <= 1'b0;
      sleep_fuse <= 1'b0;
      sleep_tsense <= 1'b0;
      sleep_clk_rx <= 1'b0;
      sleep_data_rx <= 1'b0;
      sleep_align_rx <= 1'b0;
      sleep_dataclk_rx <= 1'b0;
    end else begin
      sleep_dac_a <= sleep_s2_r & sleep_mask_r[`SLP_DAC_A];
      sleep_dac_b <= sleep_s2_r & sleep_mask_r[`SLP_DAC_B];
      sleep_fuse <= sleep_s2_r & sleep_mask_r[`SLP_FUSE];
      sleep_tsense <= sleep_s2_r & sleep_mask_r[`SLP_TSENSE];
      sleep_clk_rx <= sleep_s2_r & sleep_mask_r[`SLP_CLK_RX];
      sleep_data_rx <= sleep_s2_r & sleep_mask_r[`SLP_DATA_RX];
      sleep_align_rx <= sleep_s2_r & sleep_mask_r[`SLP_ALIGN_RX];
      sleep_dataclk_rx <= sleep_s2_r & sleep_mask_r[`SLP_DATACLK_RX];
    end
  end

endmodule

`default_nettype wire

// [include/dac_regs_map.vh]
// Register indices, reset values, field positions and write masks of the converter register slice.
// What this block does
// - Each pattern word holds 14 bits in 13:0; bits 15:14 read 00.
// - All eight pattern words form the expected sequence for input interface checking.
// - Pattern word two resets to 0x2aea, word three to 0x0545.
// - Pattern word four resets to 0x0585.
// - Pattern word five resets to 0x0949.
// - Pattern word six resets to 0x1515.
// - Pattern word seven resets to 0x3aba.
// - With override enable bit 15 set, the converter takes the static code.
// - Static code is bits 13:0, resets to zero, applied only while enabled.
// - Override enable resets to 0; bit 14 is reserved and resets to 0.
// - While the sleep pin is asserted, blocks whose mask bit is 1 sleep.
// - Sleep mask is 16 bits and resets to 0xffff.
// - Mask bit 10 data receivers, bit 8 alignment receiver, bit 7 data clock receiver.
// - Word zero resets to 0x3a7a, word one to 0x36b6, each in bits 13:0.
`ifndef DAC_REGS_MAP_VH
`define DAC_REGS_MAP_VH

`define IDX_WORD0 8'h0c
`define IDX_WORD1 8'h0d
`define IDX_WORD2 8'h0e
`define IDX_WORD3 8'h0f
`define IDX_WORD4 8'h10
`define IDX_WORD5 8'h11
`define IDX_WORD6 8'h12
`define IDX_WORD7 8'h13
`define IDX_OVERRIDE 8'h14
`define IDX_SLEEP_MASK 8'h15
`define IDX_CHECK_CTRL 8'h1a
`define IDX_CHECK_STATUS 8'h1b

`define RST_WORD0 16'h3a7a
`define RST_WORD1 16'h36b6
`define RST_WORD2 16'h2aea
`define RST_WORD3 16'h0545
`define RST_WORD4 16'h0585
`define RST_WORD5 16'h0949
`define RST_WORD6 16'h1515
`define RST_WORD7 16'h3aba
`define RST_OVERRIDE 16'h0000
`define RST_SLEEP_MASK 16'hffff
`define RST_CHECK_CTRL 16'h0000

`define WMASK_WORD 16'h3fff
`define WMASK_OVERRIDE 16'hbfff
`define WMASK_SLEEP 16'hfd80
`define WMASK_CHECK_CTRL 16'h0001

`define OVR_EN_BIT 15
`define OVR_CODE_MSB 13
`define CHK_EN_BIT 0
`define STAT_ARMED_BIT 8

`define SLP_DAC_A 15
`define SLP_DAC_B 14
`define SLP_FUSE 13
`define SLP_TSENSE 12
`define SLP_CLK_RX 11
`define SLP_DATA_RX 10
`define SLP_ALIGN_RX 8
`define SLP_DATACLK_RX 7

`endif

// [src/reg_word.v]
// One 16-bit software register with fixed reset value and per-bit write mask.
`timescale 1ns/1ps
`default_nettype none

module reg_word #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] WR_MASK = 16'hffff
) (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [15:0] wr_data,
  output reg [15:0] value_r
);

  // Masked-off bits always hold the reset value, so reserved bits ignore writes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= RESET_VAL;
    end else if (wr_en) begin
      value_r <= (wr_data & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

endmodule

`default_nettype wire

// [verification/dac_regs_properties.sv]
// Bus and output assertions of the converter register slice.
`timescale 1ns/1ps
`default_nettype none
module dac_regs_properties #(
  parameter ADDR_W = 12,
  parameter DATA_W = 14
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire sleep_pin,
  input wire [DATA_W-1:0] dac_code,
  input wire sleep_dac_a,
  input wire sleep_dataclk_rx
);
  wire [7:0] idx = paddr[9:2];
  wire ok = paddr[1:0] == 2'b00 && paddr[ADDR_W-1:10] == 0;
  wire acc = psel && penable;
  wire rd = acc && !pwrite && ok;
  wire wr = acc && pwrite && ok;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_word_resv: assert property (rd && idx >= 8'h0c && idx <= 8'h13 |-> prdata[15:14] == 2'b00)
    else $error("pattern reserved bits set");
  a_ovr_resv: assert property (rd && idx == 8'h14 |-> !prdata[14])
    else $error("override bit 14 set");
  a_mask_resv: assert property (rd && idx == 8'h15 |-> prdata[9] && prdata[6:0] == 7'h7f)
    else $error("mask reserved bits changed");
  a_bad_addr: assert property (acc && !ok |-> pslverr && prdata == 32'h0)
    else $error("bad address accepted");
  a_good_addr: assert property (acc && ok && idx >= 8'h0c && idx <= 8'h15 |-> !pslverr)
    else $error("mapped address refused");
  a_ovr_apply: assert property (wr && idx == 8'h14 && pwdata[15] |->
    ##2 dac_code == $past(pwdata[13:0], 2)) else $error("override code not applied");
  a_mask_block: assert property (wr && idx == 8'h15 && !pwdata[15] |-> ##2 !sleep_dac_a)
    else $error("masked block slept");
  a_pin_idle: assert property (!$past(sleep_pin, 3) |-> !sleep_dac_a && !sleep_dataclk_rx)
    else $error("sleep without pin");
endmodule
bind dac_test_pattern_sleep_regs dac_regs_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sleep_pin(sleep_pin), .dac_code(dac_code), .sleep_dac_a(sleep_dac_a),
  .sleep_dataclk_rx(sleep_dataclk_rx));
`default_nettype wire

// [verification/tb_dac_test_pattern_sleep_regs.sv]
// Self-checking testbench of the converter register slice.
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_dac_test_pattern_sleep_regs;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic data_sync = 0, sleep_pin = 0, pat_on = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, s = 76602;
  logic [13:0] data_in = 0, dac_code;
  logic [7:0] slp;
  logic [2:0] pk = 0;
  logic [15:0] m [12:21];
  logic [15:0] rv [12:21] = '{`RST_WORD0, `RST_WORD1, `RST_WORD2, `RST_WORD3, `RST_WORD4,
    `RST_WORD5, `RST_WORD6, `RST_WORD7, `RST_OVERRIDE, `RST_SLEEP_MASK};
  logic [15:0] wm [12:21] = '{`WMASK_WORD, `WMASK_WORD, `WMASK_WORD, `WMASK_WORD, `WMASK_WORD,
    `WMASK_WORD, `WMASK_WORD, `WMASK_WORD, `WMASK_OVERRIDE, `WMASK_SLEEP};
  int num_errors = 0, n_tests = 0, k, bad;
  always #2.5 pclk = ~pclk;
  dac_test_pattern_sleep_regs dac_test_pattern_sleep_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .data_in(data_in), .data_sync(data_sync), .sleep_pin(sleep_pin), .dac_code(dac_code),
    .sleep_dac_a(slp[7]), .sleep_dac_b(slp[6]), .sleep_fuse(slp[5]), .sleep_tsense(slp[4]),
    .sleep_clk_rx(slp[3]), .sleep_data_rx(slp[2]), .sleep_align_rx(slp[1]),
    .sleep_dataclk_rx(slp[0]));
  // Streams the eight pattern words, word zero aligned with the sync rise.
  always @(posedge pclk) begin
    if (pat_on) begin
      data_in <= m[12 + pk][13:0] ^ {13'h0, pk == bad};
      pk <= pk + 3'd1;
    end else begin
      pk <= 3'd0;
    end
    data_sync <= pat_on;
  end
  function automatic [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task wrap_up;
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task apb(input logic w, input [11:0] a, input [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      num_errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input int x, input [15:0] d);
    apb(1, x * 4, {16'h0, d});
    m[x] = (d & wm[x]) | (m[x] & ~wm[x]);
  endtask
  task rdchk(input int x);
    apb(0, x * 4, 0);
    `CHK({err, rd}, {17'h0, m[x]})
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    m = rv;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    for (k = 12; k < 22; k++) rdchk(k);
    apb(0, 12'h058, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, 12'h039, 32'hffff);
    `CHK(err, 1'b1)
    rdchk(14);
    for (k = 12; k < 22; k++) begin
      s = nx(s);
      wr(k, s[15:0]);
    end
    for (k = 12; k < 22; k++) rdchk(k);
    wr(20, 16'h8000 | s[13:0]);
    repeat (3) @(posedge pclk);
    `CHK(dac_code, m[20][13:0])
    data_in <= s[29:16];
    wr(20, s[15:0] & 16'h7fff);
    repeat (4) @(posedge pclk);
    `CHK(dac_code, data_in)
    for (k = 0; k < 4; k++) begin
      s = nx(s);
      wr(21, k == 0 ? 16'hffff : (k == 1 ? s[15:0] & 16'h7fff : s[15:0]));
      sleep_pin <= 1;
      repeat (4) @(posedge pclk);
      `CHK(slp, {m[21][15:10], m[21][8:7]})
      sleep_pin <= 0;
      repeat (4) @(posedge pclk);
      `CHK(slp, 8'h00)
    end
    for (bad = 9; bad > 0; bad -= 4) begin
      apb(1, 12'h068, 1);
      pat_on <= 1;
      repeat (20) @(posedge pclk);
      apb(0, 12'h06c, 0);
      `CHK(rd[8], 1'b1)
      apb(1, 12'h068, 0);
      pat_on <= 0;
      apb(0, 12'h06c, 0);
      `CHK(rd[7:0], bad < 8 ? 8'h01 << bad : 8'h00)
      apb(1, 12'h06c, 32'hff);
    end
    presetn <= 0;
    repeat (3) @(posedge pclk);
    `CHK({dac_code, slp}, 22'h0)
    presetn <= 1;
    m = rv;
    for (k = 12; k < 22; k++) rdchk(k);
    apb(0, 12'h06c, 0);
    `CHK(rd[8:0], 9'h000)
    wrap_up();
  end
endmodule
`default_nettype wire
